//--- brake_interlock_sequencer.v
// Brake interlock and base-circuit sequencer with AHB-Lite registers
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "brake_seq_defines.vh"

// Behaviour
// - At servo-off the brake output drops first and the base circuit stops Tb later.
// - Forced-stop deceleration is on when the stop mode holds 2, its reset value, and off at 0.
// - After servo-on is withdrawn, servo lock ends after Tb ms and the motor coasts.
// - The brake output is high to keep the brake released and low to apply it.
// - An axis in torque mode never uses forced-stop deceleration.
// - A decel forced-stop input low or a controller stop acts on all axes and drops the brake output.
// - Decel ramps a model speed to 0 and stops the base once speed is in the zero window.
// - Main power loss with control power on stops the base and applies all brakes.
// - A ready-off command puts every axis into the stopped, braked state.
// - Without decel, a stop warning or immediate input low stops base and brake at once.
// - Loss of both powers leaves all axes with base off and brake applied.
module brake_interlock_sequencer #(
    parameter AXES = 3,
    parameter MS_CYCLES = `MS_CYCLES
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire forced_stop_decel_in,
    input wire forced_stop_immediate_in,
    input wire main_power_ok_in,
    input wire control_power_ok_in,
    input wire [AXES-1:0] zero_speed_in,
    output reg [AXES-1:0] brake_interlock_out,
    output reg [AXES-1:0] base_enable_out,
    output reg all_axis_fault_out,
    output reg irq
);
    localparam ST_OFF = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_TB = 2'd2;
    localparam ST_DECEL = 2'd3;

    // Pin synchronisers, first stage read only by second
    reg [3:0] pin_s1_r;
    reg [3:0] pin_s2_r;
    reg [AXES-1:0] zs_s1_r;
    reg [AXES-1:0] zs_s2_r;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Stop and power pins reset idle-high, so no false stop edge follows reset; zero-speed resets low
            pin_s1_r <= 4'hf;
            pin_s2_r <= 4'hf;
            zs_s1_r <= {AXES{1'b0}};
            zs_s2_r <= {AXES{1'b0}};
        end else begin
            pin_s1_r <= {control_power_ok_in, main_power_ok_in,
                forced_stop_immediate_in, forced_stop_decel_in};
            pin_s2_r <= pin_s1_r;
            zs_s1_r <= zero_speed_in;
            zs_s2_r <= zs_s1_r;
        end
    end
    wire em_decel_ok = pin_s2_r[0];
    wire em_imm_ok = pin_s2_r[1];
    wire main_ok = pin_s2_r[2];
    wire ctrl_ok = pin_s2_r[3];

    // Registers
    reg ready_off_r;
    reg stop_cmd_r;
    reg [AXES-1:0] servo_on_r;
    reg [15:0] brake_delay_r;
    reg [3:0] stop_mode_r;
    reg [AXES-1:0] torque_mode_r;
    reg [15:0] decel_step_r;
    reg [`IRQ_WIDTH-1:0] irq_stat_r;
    reg [`IRQ_WIDTH-1:0] irq_mask_r;
    reg [`IRQ_WIDTH-1:0] irq_evt;

    // AHB-Lite address phase capture; zero wait states
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    wire take = hsel && hready && htrans[1];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_r <= take && hwrite;
            if (take)
                wr_addr_r <= haddr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Global stop causes
    wire decel_en = (stop_mode_r == `STOP_MODE_DECEL);
    wire power_lost = !main_ok || !ctrl_ok;
    wire fstop = !em_decel_ok || stop_cmd_r;
    // Immediate input always cuts at once; the decel input only when no ramp
    wire imm_cut = !em_imm_ok;
    wire plain_cut = fstop && !decel_en;
    wire ready_cut = ready_off_r;
    wire hard_stop = power_lost || ready_cut || imm_cut || plain_cut;

    // Brake is released only while the axis runs
    function releases_brake;
        input [1:0] st;
        begin
            releases_brake = (st == ST_RUN);
        end
    endfunction

    // Base stays energised in every state but off
    function energises_base;
        input [1:0] st;
        begin
            energises_base = (st != ST_OFF);
        end
    endfunction

    wire [AXES-1:0] brake_nxt;
    wire [AXES-1:0] base_nxt;
    wire [AXES-1:0] base_evt;
    wire [AXES-1:0] brake_evt;
    wire [15:0] model_speed [0:AXES-1];
    // A zero step would stall the ramp with the base left on
    wire [15:0] ramp_step = (decel_step_r == 16'h0000) ?
        16'h0001 : decel_step_r;
    genvar g;
    generate
        for (g = 0; g < AXES; g = g + 1) begin : axis
            reg [1:0] state_r;
            reg [1:0] st_nxt;
            reg [15:0] ms_cnt_r;
            reg [31:0] tick_r;
            reg [15:0] speed_r;
            wire tick_done = (tick_r == MS_CYCLES - 1);
            wire tb_done = (ms_cnt_r >= brake_delay_r);
            assign model_speed[g] = speed_r;
            assign brake_nxt[g] = releases_brake(st_nxt);
            assign base_nxt[g] = energises_base(st_nxt);
            assign base_evt[g] = energises_base(state_r) &&
                !energises_base(st_nxt);
            assign brake_evt[g] = releases_brake(state_r) &&
                !releases_brake(st_nxt);

            always @* begin
                st_nxt = state_r;
                case (state_r)
                    ST_OFF: begin
                        if (servo_on_r[g] && !hard_stop && !fstop)
                            st_nxt = ST_RUN;
                    end
                    ST_RUN: begin
                        if (hard_stop)
                            st_nxt = ST_OFF;
                        else if (fstop && !torque_mode_r[g])
                            st_nxt = ST_DECEL;
                        else if (fstop)
                            st_nxt = ST_OFF;
                        else if (!servo_on_r[g])
                            st_nxt = ST_TB;
                    end
                    ST_TB: begin
                        if (hard_stop || fstop)
                            st_nxt = ST_OFF;
                        else if (tb_done)
                            st_nxt = ST_OFF;
                    end
                    ST_DECEL: begin
                        if (hard_stop || torque_mode_r[g])
                            st_nxt = ST_OFF;
                        else if (speed_r == 16'h0000 && zs_s2_r[g])
                            st_nxt = ST_OFF;
                    end
                    default: st_nxt = ST_OFF;
                endcase
            end

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    state_r <= ST_OFF;
                    ms_cnt_r <= 16'h0000;
                    tick_r <= 32'h0000_0000;
                    speed_r <= 16'h0000;
                end else begin
                    state_r <= st_nxt;
                    // Millisecond count runs only while waiting Tb
                    if (st_nxt != ST_TB) begin
                        ms_cnt_r <= 16'h0000;
                        tick_r <= 32'h0000_0000;
                    end else if (tick_done) begin
                        tick_r <= 32'h0000_0000;
                        ms_cnt_r <= ms_cnt_r + 16'h0001;
                    end else begin
                        tick_r <= tick_r + 32'h0000_0001;
                    end
                    // Model speed: full while running, ramps down in decel
                    if (st_nxt == ST_RUN)
                        speed_r <= 16'hFFFF;
                    else if (st_nxt == ST_DECEL)
                        speed_r <= (speed_r > ramp_step) ?
                            speed_r - ramp_step : 16'h0000;
                    else
                        speed_r <= 16'h0000;
                end
            end
        end
    endgenerate

    // All axis outputs registered in one place, one driver each
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brake_interlock_out <= {AXES{1'b0}};
            base_enable_out <= {AXES{1'b0}};
        end else begin
            brake_interlock_out <= brake_nxt;
            base_enable_out <= base_nxt;
        end
    end

    // Sticky events
    reg fstop_d_r;
    reg power_d_r;
    reg ready_d_r;
    always @* begin
        irq_evt = {`IRQ_WIDTH{1'b0}};
        irq_evt[`IRQ_BASE_OFF_BIT] = |base_evt;
        irq_evt[`IRQ_BRAKE_ON_BIT] = |brake_evt;
        irq_evt[`IRQ_FSTOP_BIT] = (fstop || !em_imm_ok) && !fstop_d_r;
        irq_evt[`IRQ_POWER_BIT] = power_lost && !power_d_r;
        irq_evt[`IRQ_READY_OFF_BIT] = ready_off_r && !ready_d_r;
    end

    // Set wins over write-one-to-clear
    reg [`IRQ_WIDTH-1:0] irq_stat_nxt;
    always @* begin
        irq_stat_nxt = irq_stat_r | irq_evt;
        if (wr_pend_r && wr_addr_r == `REG_IRQ_STATUS)
            irq_stat_nxt = (irq_stat_r & ~hwdata[`IRQ_WIDTH-1:0]) |
                irq_evt;
    end

    // Register writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_off_r <= 1'b0;
            stop_cmd_r <= 1'b0;
            servo_on_r <= {AXES{1'b0}};
            brake_delay_r <= `BRAKE_DELAY_RESET;
            stop_mode_r <= `STOP_MODE_RESET;
            torque_mode_r <= {AXES{1'b0}};
            decel_step_r <= `DECEL_STEP_RESET;
            irq_stat_r <= {`IRQ_WIDTH{1'b0}};
            irq_mask_r <= {`IRQ_WIDTH{1'b0}};
            fstop_d_r <= 1'b0;
            power_d_r <= 1'b0;
            ready_d_r <= 1'b0;
            irq <= 1'b0;
            all_axis_fault_out <= 1'b0;
        end else begin
            fstop_d_r <= fstop || !em_imm_ok;
            power_d_r <= power_lost;
            ready_d_r <= ready_off_r;
            if (wr_pend_r) begin
                case (wr_addr_r)
                    `REG_CTRL: begin
                        ready_off_r <= hwdata[`CTRL_READY_OFF_BIT];
                        stop_cmd_r <= hwdata[`CTRL_STOP_CMD_BIT];
                        servo_on_r <=
                            hwdata[`CTRL_SERVO_ON_LSB +: AXES];
                    end
                    `REG_BRAKE_DELAY: brake_delay_r <= hwdata[15:0];
                    `REG_STOP_MODE: stop_mode_r <= hwdata[3:0];
                    `REG_TORQUE_MODE: torque_mode_r <= hwdata[AXES-1:0];
                    `REG_IRQ_MASK: irq_mask_r <= hwdata[`IRQ_WIDTH-1:0];
                    `REG_DECEL_STEP: decel_step_r <= hwdata[15:0];
                    default: begin
                    end
                endcase
            end
            irq_stat_r <= irq_stat_nxt;
            // Follows the next status so a clear drops the line at once
            irq <= |(irq_stat_nxt & irq_mask_r);
            // Fault line: low while any global stop cause stands
            all_axis_fault_out <= !(hard_stop || fstop);
        end
    end

    // Read data, registered in the data phase
    integer i;
    reg [31:0] status_w;
    always @* begin
        status_w = 32'h0000_0000;
        for (i = 0; i < AXES; i = i + 1) begin
            status_w[i] = brake_interlock_out[i];
            status_w[8 + i] = base_enable_out[i];
        end
        status_w[16] = em_decel_ok;
        status_w[17] = em_imm_ok;
        status_w[18] = main_ok;
        status_w[19] = ctrl_ok;
        status_w[20] = decel_en;
        status_w[31:24] = model_speed[0][15:8];
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr)
                `REG_CTRL: hrdata <= {{(24-AXES){1'b0}}, servo_on_r,
                    6'h00, stop_cmd_r, ready_off_r};
                `REG_BRAKE_DELAY: hrdata <= {16'h0000, brake_delay_r};
                `REG_STOP_MODE: hrdata <= {28'h000_0000, stop_mode_r};
                `REG_TORQUE_MODE:
                    hrdata <= {{(32-AXES){1'b0}}, torque_mode_r};
                `REG_STATUS: hrdata <= status_w;
                `REG_IRQ_STATUS:
                    hrdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_stat_r};
                `REG_IRQ_MASK:
                    hrdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_mask_r};
                `REG_DECEL_STEP: hrdata <= {16'h0000, decel_step_r};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // brake_interlock_sequencer

//--- brake_seq_defines.vh
// Register offsets, field positions, reset values and timing counts
`ifndef BRAKE_SEQ_DEFINES_VH
`define BRAKE_SEQ_DEFINES_VH
`define CLK_FREQ_HZ 10000000
`define MS_CYCLES (`CLK_FREQ_HZ / 1000)
`define REG_CTRL 8'h00
`define REG_BRAKE_DELAY 8'h04
`define REG_STOP_MODE 8'h08
`define REG_TORQUE_MODE 8'h0C
`define REG_STATUS 8'h10
`define REG_IRQ_STATUS 8'h14
`define REG_IRQ_MASK 8'h18
`define REG_DECEL_STEP 8'h1C
`define CTRL_READY_OFF_BIT 0
`define CTRL_STOP_CMD_BIT 1
`define CTRL_SERVO_ON_LSB 8
`define STOP_MODE_DECEL 4'h2
`define STOP_MODE_NONE 4'h0
`define STOP_MODE_RESET 4'h2
`define BRAKE_DELAY_RESET 16'h0064
`define DECEL_STEP_RESET 16'h0010
`define IRQ_BASE_OFF_BIT 0
`define IRQ_BRAKE_ON_BIT 1
`define IRQ_FSTOP_BIT 2
`define IRQ_POWER_BIT 3
`define IRQ_READY_OFF_BIT 4
`define IRQ_WIDTH 5
`endif

//--- brake_seq_checker.sv
// Port-level assertions for the brake interlock sequencer
`timescale 1ns/10ps
module brake_seq_checker #(
    parameter AXES = 3
) (
    input logic hclk,
    input logic hresetn,
    input logic hreadyout,
    input logic hresp,
    input logic forced_stop_decel_in,
    input logic forced_stop_immediate_in,
    input logic main_power_ok_in,
    input logic control_power_ok_in,
    input logic [AXES-1:0] brake_interlock_out,
    input logic [AXES-1:0] base_enable_out,
    input logic all_axis_fault_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Bounds allow two sync stages plus the output register
    wire all_off = (brake_interlock_out == 0) && (base_enable_out == 0);
    a_brake_base_order: assert property (
        (brake_interlock_out & ~base_enable_out) == 0)
        else $error("brake released while base is off");
    a_servo_lock_hold: assert property (
        $fell(brake_interlock_out[0]) && base_enable_out[0]
        |=> base_enable_out[0] [*8])
        else $error("base cut too soon after brake drop");
    a_imm_stop_cut: assert property (
        $fell(forced_stop_immediate_in) |-> ##[1:5] all_off)
        else $error("immediate stop did not cut outputs");
    a_main_loss_cut: assert property (
        $fell(main_power_ok_in) |-> ##[1:5] all_off)
        else $error("main power loss did not cut outputs");
    a_both_power_off: assert property (
        (!main_power_ok_in && !control_power_ok_in) [*6] |-> all_off)
        else $error("outputs on without power");
    a_decel_brake_drop: assert property (
        $fell(forced_stop_decel_in) |-> ##[1:5] brake_interlock_out == 0)
        else $error("forced stop left a brake released");
    a_fault_on_loss: assert property (
        !main_power_ok_in [*5] |-> !all_axis_fault_out)
        else $error("fault output high during power loss");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered error");
    cover property ($fell(brake_interlock_out[0]) && base_enable_out[0]);
    cover property ($fell(forced_stop_decel_in));
    cover property ($fell(main_power_ok_in));
endmodule // brake_seq_checker

//--- motion_ctrl_model.sv
// Motion controller model: AHB-Lite master issuing register commands
`timescale 1ns/10ps
module motion_ctrl_model (
    input logic hclk,
    input logic hready,
    input logic [31:0] hrdata,
    output logic hsel = 1'h0,
    output logic [7:0] haddr = 8'h00,
    output logic [1:0] htrans = 2'h0,
    output logic hwrite = 1'h0,
    output logic [2:0] hsize = 3'h2,
    output logic [31:0] hwdata = 32'h0000_0000
);
    // Single word transfer; waits on hready with no assumed latency
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        // Reads drive toggled junk so stale write data is never reused
        hwdata <= wr ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'h1);
        q = hrdata;
    endtask
endmodule // motion_ctrl_model

//--- tb_brake_interlock_sequencer.sv
// Self-checking bench for the brake interlock sequencer
`timescale 1ns/10ps
`include "brake_seq_defines.vh"
module tb_brake_interlock_sequencer;
    localparam int MS = 10;
    logic hclk = 0, hresetn = 0, forced_stop_decel_in = 1;
    logic forced_stop_immediate_in = 1, main_power_ok_in = 1;
    logic control_power_ok_in = 1, hsel, hwrite, hreadyout, hresp;
    logic all_axis_fault_out, irq;
    logic [1:0] htrans;
    logic [2:0] hsize, brake_interlock_out, base_enable_out;
    logic [2:0] zero_speed_in = 3'h7;
    logic [7:0] haddr;
    logic [31:0] hwdata, hrdata, q, d, seed = 32'h0000_5821;
    int n_mismatch = 0, comparisons = 0, cyc = 0, n, tb_ms;
    always #50 hclk = ~hclk;
    motion_ctrl_model ctl (.hclk, .hready(hreadyout), .hrdata, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata);
    brake_interlock_sequencer #(.AXES(3), .MS_CYCLES(MS)) dut (.hclk,
        .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .forced_stop_decel_in, .forced_stop_immediate_in,
        .main_power_ok_in, .control_power_ok_in, .zero_speed_in,
        .brake_interlock_out, .base_enable_out, .all_axis_fault_out, .irq);
    task stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task wr(input logic [7:0] a, input logic [31:0] v);
        ctl.xfer(1'h1, a, v, q);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        ctl.xfer(1'h0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask
    // Clear every stop cause, servo-on all axes, wait for brakes released
    task run();
        forced_stop_decel_in <= 1;
        forced_stop_immediate_in <= 1;
        main_power_ok_in <= 1;
        control_power_ok_in <= 1;
        wr(`REG_CTRL, 32'h0000_0700);
        n = 0;
        while (brake_interlock_out !== 3'h7 && n < 5000) begin
            @(posedge hclk);
            n++;
        end
        chk({base_enable_out, brake_interlock_out}, 32'h0000_003f);
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        repeat (3) @(posedge hclk);
        rd(`REG_BRAKE_DELAY, 32'h0000_0064);
        rd(`REG_STOP_MODE, 32'h0000_0002);
        rd(`REG_DECEL_STEP, 32'h0000_0010);
        rd(8'h40, 32'h0000_0000);
        ctl.xfer(1'h0, `REG_STATUS, 32'h0000_0000, q);
        chk(q[20], 1);
        d = (rnd() & 32'h0000_00ff) | 32'h0000_0010;
        wr(`REG_DECEL_STEP, d);
        rd(`REG_DECEL_STEP, d);
        wr(`REG_IRQ_MASK, 32'h0000_0000);
        run();
        for (int ax = 0; ax < 3; ax++) begin
            tb_ms = rnd() % 4 + 1; // Short delay stands in for 1.5x
            wr(`REG_BRAKE_DELAY, tb_ms);
            zero_speed_in <= 3'h7; // Motor at rest before servo-off
            wr(`REG_CTRL, 32'h0000_0700 & ~(32'h0000_0100 << ax));
            n = 0;
            while (base_enable_out[ax] === 1'h1 && n < 100) begin
                @(posedge hclk);
                n++;
                if (n == 2) chk(brake_interlock_out[ax], 0);
            end
            chk(n >= tb_ms * MS - 2 && n <= tb_ms * MS + 2, 1);
            run();
        end
        zero_speed_in <= 3'h0;
        wr(`REG_CTRL, 32'h0000_0702);
        repeat (12) @(posedge hclk);
        chk({base_enable_out, brake_interlock_out}, 32'h0000_0038);
        zero_speed_in <= 3'h7;
        run();
        zero_speed_in <= 3'h0;
        wr(`REG_TORQUE_MODE, 32'h0000_0004);
        forced_stop_decel_in <= 0;
        repeat (6) @(posedge hclk);
        chk({base_enable_out, brake_interlock_out}, 32'h0000_0018);
        chk(irq, 0);
        wr(`REG_IRQ_MASK, 32'h0000_001f);
        repeat (3) @(posedge hclk);
        chk(irq, 1);
        zero_speed_in <= 3'h7;
        n = 0;
        while (base_enable_out !== 3'h0 && n < 5000) begin
            @(posedge hclk);
            n++;
        end
        chk(base_enable_out, 0);
        wr(`REG_IRQ_STATUS, 32'h0000_001f);
        repeat (3) @(posedge hclk);
        chk(irq, 0);
        wr(`REG_TORQUE_MODE, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            run();
            case (i)
                0: forced_stop_immediate_in <= 0;
                1: main_power_ok_in <= 0;
                2: begin
                    main_power_ok_in <= 0;
                    control_power_ok_in <= 0;
                end
                3: wr(`REG_CTRL, 32'h0000_0701);
                default: begin
                    wr(`REG_STOP_MODE, 32'h0000_0000);
                    wr(`REG_CTRL, 32'h0000_0702);
                end
            endcase
            repeat (6) @(posedge hclk);
            chk({base_enable_out, brake_interlock_out}, 0);
        end
        stop_test();
    end
endmodule // tb_brake_interlock_sequencer
bind brake_interlock_sequencer brake_seq_checker #(.AXES(AXES)) u_chk (
    .hclk, .hresetn, .hreadyout, .hresp, .forced_stop_decel_in,
    .forced_stop_immediate_in, .main_power_ok_in, .control_power_ok_in,
    .brake_interlock_out, .base_enable_out, .all_axis_fault_out);
